// ---- verilog/qop_pkg.sv ----
package qop_pkg;

  localparam int unsigned LANES = 4;
  localparam int unsigned SYM_W = 2;

  // symbol and optical level codes: code 3 is the brightest level
  localparam logic [SYM_W-1:0] SYM_THREE   = 2'h3;
  localparam logic [SYM_W-1:0] SYM_ZERO    = 2'h0;
  localparam logic [SYM_W-1:0] LEVEL_HIGH  = 2'h3;
  localparam logic [SYM_W-1:0] LEVEL_LOW   = 2'h0;

  // management bit positions (device 1 registers)
  localparam int unsigned REG_CTRL1_IDX      = 0;
  localparam int unsigned REG_STAT1_IDX      = 1;
  localparam int unsigned REG_STAT2_IDX      = 8;
  localparam int unsigned REG_TXOFF_IDX      = 9;
  localparam int unsigned REG_DETECT_IDX     = 10;
  localparam int unsigned BIT_RESET          = 15;
  localparam int unsigned BIT_LOCAL_FAULT    = 7;
  localparam int unsigned BIT_TX_FAULT       = 11;
  localparam int unsigned BIT_RX_FAULT       = 10;
  localparam int unsigned BIT_ALL_OFF        = 0;
  localparam int unsigned BIT_LANE_OFF0      = 1;
  localparam int unsigned BIT_GLOBAL_PRESENT = 0;
  localparam int unsigned BIT_LANE_PRESENT0  = 1;

  // reset values
  localparam logic [15:0] REG_RESET_VALUE = 16'h0000;

  // timing: sublayer reset is held internally for this long
  localparam int unsigned CLK_MHZ           = 50;
  localparam int unsigned SOFT_RESET_NS     = 200;
  localparam int unsigned SOFT_RESET_CYCLES =
    (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned TX_FIFO_DEPTH = 4;

  typedef logic [LANES-1:0][SYM_W-1:0] qop_lanes_t;

  typedef struct packed {
    logic             globalPresent;
    logic [LANES-1:0] lanePresent;
    logic             localFault;
    logic             txPathFault;
    logic             rxPathFault;
  } qop_status_t;

  typedef struct packed {
    logic [15:0] stat1;
    logic [15:0] stat2;
    logic [15:0] txOff;
    logic [15:0] detect;
  } qop_regs_t;

endpackage : qop_pkg

// ---- verilog/qop_fifo.sv ----
module qop_fifo
  import qop_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = TX_FIFO_DEPTH
)
(
  // clock, reset, enable and flush
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic             flush,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("qop_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  wire              doWrite;
  wire              doRead;
  wire              isFull;
  wire              isEmpty;

  assign isEmpty  = (wrPtr_q == rdPtr_q);
  assign isFull   = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
  assign inReady  = ~isFull & ~flush;
  assign outValid = ~isEmpty & ~flush;
  assign doWrite  = ce & inValid & inReady;
  assign doRead   = ce & outValid & outReady;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (doWrite)
      mem[wrPtr_q[AW-1:0]] <= inData;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wrPtr_q <= '0;
        rdPtr_q <= '0;
      end
      else
      begin
        if (doWrite)
          wrPtr_q <= wrPtr_q + 1'b1;
        if (doRead)
          rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  // a stalled head must not move: a write into a full buffer would overrun it
  fifo_head_hold_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && !flush && outValid && !outReady |=> $stable(outData))
    else $error("fifo head changed while stalled");

endmodule : qop_fifo

// ---- verilog/qop_pmd_ctrl.sv ----
// Behaviour
// - four lane send symbol streams become four separate optical lane drives
// - tx symbol three drives highest level, symbol zero the lowest
// - highest received level decodes to three, lowest to zero, per lane
// - presence flag shown continuously; notice pulses on every flag change
// - global presence is OK only with light on all four lanes
// - any lane at or below the low-power threshold forces FAIL
// - all lanes above minimum power gives OK; otherwise flag holds
// - no compliance check on presence; update latency unconstrained
// - one light-present flag per lane, same FAIL and OK conditions
// - asserting the sublayer reset control resets the optical sublayer
// - all-lane transmit off turns every transmitter off
// - a lane transmit off turns only that lane's transmitter off
// - on local fault the device may force all transmitters off itself
// - a separate test input can disable each transmit lane
// - local fault flag set on any transmit or receive path fault
// - transmit path fault flag set on any transmit lane fault
// - receive path fault flag set on any receive lane fault
// - electrical lane i maps straight to optical lane i
// - control bits: reset 1.0.15, all-off 1.9.0, lane off 1.9.1-4
// - status bits: local fault 1.1.7, tx fault 1.8.11, rx 1.8.10
// - presence bits: global 1.10.0, lanes 1.10.1 to 1.10.4
// - presence has two values; symbols undefined while FAIL
module qop_pmd_ctrl
  import qop_pkg::*;
#(
  parameter bit AUTO_OFF_ON_FAULT = 1'b0
)
(
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // management control words (registers 1.0 and 1.9)
  input  wire logic [15:0]      ctrl1Word,
  input  wire logic [15:0]      txOffWord,
  input  wire logic [LANES-1:0] testLaneOff,
  // management status
  output qop_regs_t             mgmtRegs,
  output qop_status_t           status,
  output logic                  resetBusy,
  // lane_symbol_send from the attachment sublayer
  input  wire logic             sendValid,
  output logic                  sendReady,
  input  wire qop_lanes_t       sendSymbols,
  // optical transmit drivers
  input  wire logic             txDrvReady,
  output qop_lanes_t            txLevel,
  output logic [LANES-1:0]      txLaserOn,
  // optical receive front end (asynchronous pins)
  input  wire qop_lanes_t       rxLevelPin,
  input  wire logic [LANES-1:0] rxPowerLowPin,
  input  wire logic [LANES-1:0] rxPowerOkPin,
  input  wire logic [LANES-1:0] txFaultPin,
  input  wire logic [LANES-1:0] rxFaultPin,
  // lane_symbol_deliver and presence to the attachment sublayer
  output qop_lanes_t            deliverSymbols,
  output logic                  deliverValid,
  output logic                  presenceOk,
  output logic                  presenceChangeNotice
);

  localparam int unsigned SYNC_W = 4 * LANES + LANES * SYM_W;
  localparam int unsigned RST_W  = $clog2(SOFT_RESET_CYCLES + 1);
  localparam logic [RST_W-1:0] RST_LOAD = RST_W'(SOFT_RESET_CYCLES);

  initial
  begin
    if (LANES != 4 || SYM_W != 2)
      $error("qop_pmd_ctrl: built for four lanes of two-bit symbols");
  end

  // management reset: rising edge of the control bit starts a timed reset
  wire             resetCtrl;
  logic            resetCtrl_q;
  logic [RST_W-1:0] rstCnt_q;
  wire             resetStart;

  assign resetCtrl  = ctrl1Word[BIT_RESET];
  assign resetStart = resetCtrl & ~resetCtrl_q;
  assign resetBusy  = (rstCnt_q != '0);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resetCtrl_q <= 1'b0;
      rstCnt_q    <= '0;
    end
    else if (ce)
    begin
      resetCtrl_q <= resetCtrl;
      if (resetStart)
        rstCnt_q <= RST_LOAD;
      else if (resetBusy)
        rstCnt_q <= rstCnt_q - 1'b1;
    end
  end

  // two-stage synchroniser for every pin-side input
  logic [SYNC_W-1:0] syncA_q;
  logic [SYNC_W-1:0] syncB_q;
  wire  [SYNC_W-1:0] syncIn;

  assign syncIn = {rxPowerLowPin, rxPowerOkPin, txFaultPin, rxFaultPin, rxLevelPin};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_q <= '0;
      syncB_q <= '0;
    end
    else if (ce)
    begin
      syncA_q <= syncIn;
      syncB_q <= syncA_q;
    end
  end

  wire [LANES-1:0] powerLow;
  wire [LANES-1:0] powerOk;
  wire [LANES-1:0] txFaultSync;
  wire [LANES-1:0] rxFaultSync;
  qop_lanes_t      rxLevelSync;

  assign {powerLow, powerOk, txFaultSync, rxFaultSync, rxLevelSync} = syncB_q;

  // presence: FAIL wins, OK needs power above minimum, else hold
  logic [LANES-1:0] lanePresent_q;
  logic [LANES-1:0] lanePresent_d;
  logic             globalPresent_q;
  logic             globalPresent_d;
  wire              anyLow;
  wire              allOk;

  assign anyLow = |powerLow;
  assign allOk  = &(powerOk & ~powerLow);
  assign lanePresent_d = (lanePresent_q | (powerOk & ~powerLow)) & ~powerLow;
  assign globalPresent_d = anyLow ? 1'b0
                         : allOk  ? 1'b1
                         : globalPresent_q;

  // faults follow the synchronised conditions level for level
  logic txPathFault_q;
  logic rxPathFault_q;

  // receive symbols and presence notice
  logic       presenceNotice_q;
  qop_lanes_t deliver_q;
  qop_lanes_t rxDecoded;

  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      case (rxLevelSync[i])
        LEVEL_HIGH: rxDecoded[i] = SYM_THREE;
        LEVEL_LOW:  rxDecoded[i] = SYM_ZERO;
        default:    rxDecoded[i] = rxLevelSync[i];
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lanePresent_q    <= '0;
      globalPresent_q  <= 1'b0;
      presenceNotice_q <= 1'b0;
      txPathFault_q    <= 1'b0;
      rxPathFault_q    <= 1'b0;
      deliver_q        <= '0;
    end
    else if (ce)
    begin
      if (resetBusy)
      begin
        lanePresent_q    <= '0;
        globalPresent_q  <= 1'b0;
        presenceNotice_q <= globalPresent_q; // a forced drop is still a change
        txPathFault_q    <= 1'b0;
        rxPathFault_q    <= 1'b0;
        deliver_q        <= '0;
      end
      else
      begin
        lanePresent_q    <= lanePresent_d;
        globalPresent_q  <= globalPresent_d;
        presenceNotice_q <= globalPresent_d ^ globalPresent_q;
        txPathFault_q    <= |txFaultSync;
        rxPathFault_q    <= |rxFaultSync;
        deliver_q        <= rxDecoded;
      end
    end
  end

  wire localFault;

  assign localFault           = txPathFault_q | rxPathFault_q;
  assign presenceOk           = globalPresent_q;
  assign presenceChangeNotice = presenceNotice_q & ce;
  assign deliverSymbols       = deliver_q;
  assign deliverValid         = globalPresent_q;

  // transmit path: symbols queue in a small FIFO ahead of the drivers
  wire             fifoValid;
  qop_lanes_t      fifoData;
  wire             txLoad;
  qop_lanes_t      txLevel_q;
  qop_lanes_t      txMapped;

  qop_fifo #(
    .WIDTH (LANES * SYM_W),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_txFifo (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .flush    (resetBusy),
    .inValid  (sendValid),
    .inReady  (sendReady),
    .inData   (sendSymbols),
    .outValid (fifoValid),
    .outReady (txDrvReady),
    .outData  (fifoData)
  );

  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      case (fifoData[i])
        SYM_THREE: txMapped[i] = LEVEL_HIGH;
        SYM_ZERO:  txMapped[i] = LEVEL_LOW;
        default:   txMapped[i] = fifoData[i];
      endcase
    end
  end

  assign txLoad = fifoValid & txDrvReady;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      txLevel_q <= '0;
    else if (ce)
    begin
      if (resetBusy)
        txLevel_q <= '0;
      else if (txLoad)
        txLevel_q <= txMapped;
    end
  end

  assign txLevel = txLevel_q;

  // transmitter enables; the fault-driven shutdown is an optional strap
  wire             allOff;
  wire [LANES-1:0] laneOff;
  wire             faultOff;
  logic [LANES-1:0] txOn_q;

  assign allOff   = txOffWord[BIT_ALL_OFF];
  assign laneOff  = txOffWord[BIT_LANE_OFF0 +: LANES];
  assign faultOff = AUTO_OFF_ON_FAULT & localFault;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      txOn_q <= '0;
    else if (ce)
      txOn_q <= ~({LANES{allOff | faultOff | resetBusy}} | laneOff | testLaneOff);
  end

  assign txLaserOn = txOn_q;

  // status views
  always_comb
  begin
    mgmtRegs = '0;
    mgmtRegs.stat1[BIT_LOCAL_FAULT]                = localFault;
    mgmtRegs.stat2[BIT_TX_FAULT]                   = txPathFault_q;
    mgmtRegs.stat2[BIT_RX_FAULT]                   = rxPathFault_q;
    mgmtRegs.txOff[BIT_ALL_OFF]                    = allOff | faultOff;
    mgmtRegs.txOff[BIT_LANE_OFF0 +: LANES]         = laneOff | {LANES{faultOff}};
    mgmtRegs.detect[BIT_GLOBAL_PRESENT]            = globalPresent_q;
    mgmtRegs.detect[BIT_LANE_PRESENT0 +: LANES]    = lanePresent_q;
  end

  assign status = '{globalPresent: globalPresent_q, lanePresent: lanePresent_q,
                    localFault: localFault, txPathFault: txPathFault_q,
                    rxPathFault: rxPathFault_q};

  // checks
  low_forces_fail_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && anyLow ##1 1 |-> !globalPresent_q) else $error("low lane left presence OK");

  all_ok_sets_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && !resetBusy && allOk |=> globalPresent_q) else $error("presence not OK");

  notice_on_change_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && $changed(globalPresent_q) |-> presenceChangeNotice)
    else $error("presence change without notice");

  notice_needs_change_a : assert property (@(posedge clk) disable iff (!arst_n)
    presenceChangeNotice |-> $changed(globalPresent_q)) else $error("spurious notice");

  lane_low_fail_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && powerLow[0] |=> !lanePresent_q[0]) else $error("lane 0 presence not FAIL");

  all_off_dark_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && allOff |=> txLaserOn == '0) else $error("transmitter on under all-off");

  lane_off_only_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && laneOff == 4'h2 && !allOff && !faultOff && !resetBusy && testLaneOff == '0
    |=> txLaserOn == 4'hd) else $error("lane off touched other lanes");

  fault_flags_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && !resetBusy && |txFaultSync |=> txPathFault_q && localFault)
    else $error("tx fault not flagged");

  rx_fault_flag_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && !resetBusy && |rxFaultSync |=> rxPathFault_q) else $error("rx fault lost");

  reset_timed_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && resetStart |=> resetBusy [*8] ##1 resetBusy [*2] ##1 (!resetBusy || !ce))
    else $error("sublayer reset length wrong");

  tx_map_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && !resetBusy && txLoad && fifoData[0] == SYM_THREE |=> txLevel[0] == LEVEL_HIGH)
    else $error("symbol three not brightest");

  rx_map_a : assert property (@(posedge clk) disable iff (!arst_n)
    ce && !resetBusy && rxLevelSync[1] == LEVEL_LOW |=> deliverSymbols[1] == SYM_ZERO)
    else $error("lowest level not symbol zero");

  cover_presence_up_c : cover property (@(posedge clk) disable iff (!arst_n)
    $rose(globalPresent_q));
  cover_fifo_full_c : cover property (@(posedge clk) disable iff (!arst_n)
    sendValid && !sendReady);
  cover_reset_c : cover property (@(posedge clk) disable iff (!arst_n) resetStart);
  cover_lane_off_c : cover property (@(posedge clk) disable iff (!arst_n)
    txLaserOn != '0 && txLaserOn != 4'hf);

endmodule : qop_pmd_ctrl

// ---- tb/qop_optic_model.sv ----
module qop_optic_model
  import qop_pkg::*;
(
  // clock
  input  wire logic             clk,
  // bench controls
  input  wire logic             stall,
  input  wire logic [LANES-1:0] laneLit,
  input  wire qop_lanes_t       laneLevel,
  // device side pins
  output logic                  txDrvReady,
  output qop_lanes_t            rxLevelPin,
  output logic [LANES-1:0]      rxPowerLowPin,
  output logic [LANES-1:0]      rxPowerOkPin
);
  timeunit 1ns;
  timeprecision 1ps;

  qop_lanes_t noise = 8'h00;

  // a dark lane carries no symbol: a changing pattern keeps stale values from passing
  always @(posedge clk) noise <= noise + 8'h35;

  assign txDrvReady = ~stall;
  assign rxPowerLowPin = ~laneLit;
  assign rxPowerOkPin = laneLit;

  always_comb
  begin
    for (int i = 0; i < LANES; i++)
      rxLevelPin[i] = laneLit[i] ? laneLevel[i] : noise[i];
  end
endmodule : qop_optic_model

// ---- tb/qop_pmd_ctrl_tb.sv ----
module qop_pmd_ctrl_tb
  import qop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [15:0] ctrl1Word = 16'h0000;
  logic [15:0] txOffWord = 16'h0000;
  logic [LANES-1:0] testLaneOff = 4'h0;
  logic sendValid = 1'b0;
  qop_lanes_t sendSymbols = 8'h00;
  logic stall = 1'b0;
  logic [LANES-1:0] laneLit = 4'h0;
  qop_lanes_t laneLevel = 8'h00;
  logic [LANES-1:0] txFaultPin = 4'h0;
  logic [LANES-1:0] rxFaultPin = 4'h0;
  qop_regs_t mgmtRegs;
  qop_status_t status;
  logic resetBusy, sendReady, txDrvReady, deliverValid, presenceOk, presenceChangeNotice;
  qop_lanes_t txLevel, rxLevelPin, deliverSymbols;
  logic [LANES-1:0] txLaserOn, rxPowerLowPin, rxPowerOkPin;
  int fails = 0;
  int check_count = 0;
  int noticeCount = 0;
  logic [16:0] seed = 17'd98106;
  qop_lanes_t q[$];

  always #10 clk = ~clk;

  qop_pmd_ctrl u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .ctrl1Word(ctrl1Word),
    .txOffWord(txOffWord), .testLaneOff(testLaneOff), .mgmtRegs(mgmtRegs), .status(status),
    .resetBusy(resetBusy), .sendValid(sendValid), .sendReady(sendReady),
    .sendSymbols(sendSymbols), .txDrvReady(txDrvReady), .txLevel(txLevel),
    .txLaserOn(txLaserOn), .rxLevelPin(rxLevelPin), .rxPowerLowPin(rxPowerLowPin),
    .rxPowerOkPin(rxPowerOkPin), .txFaultPin(txFaultPin), .rxFaultPin(rxFaultPin),
    .deliverSymbols(deliverSymbols), .deliverValid(deliverValid), .presenceOk(presenceOk),
    .presenceChangeNotice(presenceChangeNotice));

  qop_optic_model u_optic (.clk(clk), .stall(stall), .laneLit(laneLit),
    .laneLevel(laneLevel), .txDrvReady(txDrvReady), .rxLevelPin(rxLevelPin),
    .rxPowerLowPin(rxPowerLowPin), .rxPowerOkPin(rxPowerOkPin));

  always @(posedge clk) if (presenceChangeNotice === 1'b1) noticeCount++;

  function automatic logic [7:0] rnd();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return seed[7:0];
  endfunction : rnd

  // laser on unless the global, lane or test disable asks for it off
  function automatic logic [3:0] expLaser(logic [4:0] off, logic [3:0] tst);
    return ~({4{off[0]}} | off[4:1] | tst);
  endfunction : expLaser

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // leaves sendValid high so back-to-back words need no extra edge
  task automatic send(input qop_lanes_t w);
    int n;
    sendValid = 1'b1;
    sendSymbols = w;
    for (n = 0; n < 40 && sendReady !== 1'b1; n++) tick();
    tick();
  endtask : send

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #200000;
    fails++;
    end_sim();
  end

  initial
  begin
    int n;
    logic [7:0] v;
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    check({txLaserOn, presenceOk, sendReady}, 16'h0001);
    // single words, corner codes first
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd();
      send(v);
      sendValid = 1'b0;
      tick(3);
      check(txLevel, v);
    end
    // fill the buffer while the driver stalls, then drain one word at a time
    stall = 1'b1;
    for (int i = 0; i < TX_FIFO_DEPTH; i++)
    begin
      q.push_back(rnd());
      send(q[i]);
    end
    sendValid = 1'b0;
    tick();
    check(sendReady, 1'b0);
    for (int i = 0; i <= TX_FIFO_DEPTH; i++)
    begin
      stall = 1'b0;
      tick();
      stall = 1'b1;
      tick(2);
      check(txLevel, q[i < TX_FIFO_DEPTH ? i : TX_FIFO_DEPTH - 1]);
    end
    stall = 1'b0;
    // presence on all lanes, then each lane dark in turn
    laneLit = 4'hf;
    tick(4);
    check({presenceOk, mgmtRegs.detect[4:0], status.lanePresent}, 16'h3ff);
    check(16'(noticeCount), 16'h0001);
    for (int k = 0; k < LANES; k++)
    begin
      laneLit = ~(4'h1 << k);
      tick(4);
      check({presenceOk, status.globalPresent, deliverValid}, 3'h0);
      check(mgmtRegs.detect[4:0], {laneLit, 1'b0});
      laneLit = 4'hf;
      tick(4);
      check(presenceOk, 1'b1);
      check(16'(noticeCount), 16'(2 * k + 3));
    end
    for (int i = 0; i < 8; i++)
    begin
      laneLevel = (i == 0) ? 8'he4 : rnd();
      tick(4);
      check({deliverValid, deliverSymbols}, {1'b1, laneLevel});
    end
    // every transmit off word pattern, with random test disables in the second half
    for (int i = 0; i < 32; i++)
    begin
      txOffWord = {11'h000, i[4:0]};
      v = rnd();
      testLaneOff = (i < 16) ? 4'h0 : v[3:0];
      tick(2);
      check(txLaserOn, expLaser(i[4:0], testLaneOff));
      check(mgmtRegs.txOff, {11'h000, i[4:0]});
    end
    txOffWord = 16'h0000;
    testLaneOff = 4'h0;
    // with the enable low the lasers must ignore a new off word
    tick(2);
    ce = 1'b0;
    txOffWord = 16'h0001;
    tick(2);
    check(txLaserOn, 4'hf);
    ce = 1'b1;
    tick(2);
    check(txLaserOn, 4'h0);
    txOffWord = 16'h0000;
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h10 : rnd();
      {rxFaultPin, txFaultPin} = v;
      tick(4);
      check(status.localFault, |v);
      check({status.txPathFault, status.rxPathFault}, {|v[3:0], |v[7:4]});
      check({mgmtRegs.stat1[7], mgmtRegs.stat2[11:10]}, {|v, |v[3:0], |v[7:4]});
    end
    {rxFaultPin, txFaultPin} = 8'h00;
    // sublayer reset from the management control word
    tick(4);
    ctrl1Word = 16'h8000;
    for (n = 0; n < 4 && resetBusy !== 1'b1; n++) tick();
    check({sendReady, resetBusy}, 2'h1);
    for (n = 0; n < 40 && resetBusy === 1'b1; n++) tick();
    check(16'(n), 16'(SOFT_RESET_CYCLES));
    check({txLaserOn, presenceOk, txLevel}, 13'h0000);
    ctrl1Word = 16'h0000;
    check(16'(noticeCount), 16'h000a);
    end_sim();
  end
endmodule : qop_pmd_ctrl_tb
